// >>> src/sysctl_pkg.sv
// Package of offsets, field positions, reset values and types for the system control registers.
package sysctl_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int             REG_ADDR_W    = 8;
   localparam logic [7:0]     OFS_APP_CTRL  = 8'h0c;
   localparam logic [7:0]     OFS_LOW_POWER = 8'h10;
   localparam logic [7:0]     OFS_FIXED_CFG = 8'h14;

   // ****************************************************************
   // Application interrupt and reset control fields
   // ****************************************************************
   localparam int             KEY_MSB            = 31;
   localparam int             KEY_LSB            = 16;
   localparam logic [15:0]    WRITE_KEY          = 16'h05fa;
   localparam int             BYTE_ORDER_BIT     = 15;
   localparam int             SYS_RESET_BIT      = 2;
   localparam int             DEBUG_CLEAR_BIT    = 1;

   // ****************************************************************
   // Low-power control fields
   // ****************************************************************
   localparam int             EVENT_ON_PEND_BIT  = 4;
   localparam int             DEEP_SELECT_BIT    = 2;
   localparam int             ON_RETURN_BIT      = 1;

   // ****************************************************************
   // Fixed behaviour configuration fields
   // ****************************************************************
   localparam int             FRAME_ALIGN_BIT    = 9;
   localparam int             MISALIGN_TRAP_BIT  = 3;
   localparam logic [31:0]    FIXED_CFG_VALUE    = 32'h0000_0208;

   // ****************************************************************
   // Exception frame alignment
   // ****************************************************************
   localparam int             PSR_PAD_BIT        = 9;
   localparam logic [31:0]    FRAME_PAD_BYTES    = 32'h0000_0004;

   // Software-visible low-power control bits.
   typedef struct packed {
      logic event_on_pending;
      logic deep_low_power_select;
      logic low_power_on_handler_return;
   } low_power_ctrl_t;

   localparam low_power_ctrl_t LOW_POWER_RESET = '{1'b0, 1'b0, 1'b0};

   // Width of one data access made by the processor.
   typedef enum logic [1:0] {
      SIZE_BYTE,
      SIZE_HALF,
      SIZE_WORD
   } access_size_t;

   // One data access presented for the alignment check.
   typedef struct packed {
      logic         valid;
      access_size_t size;
      logic [1:0]   addr_lo;
   } data_access_t;

   // Power state of the processor core.
   typedef enum {
      PWR_RUN,
      PWR_WAIT_EVENT,
      PWR_SLEEP
   } power_state_t;

endpackage

// >>> src/frame_align.sv
// Exception stack frame alignment: pads on entry and undoes the pad on return.
`timescale 1ns/1ns
module frame_align
   import sysctl_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rstn_i,
   input  wire logic        exc_entry_i,
   input  wire logic [31:0] entry_sp_i,
   input  wire logic        exc_return_i,
   input  wire logic [31:0] frame_top_i,
   input  wire logic [31:0] stacked_psr_i,
   output logic      [31:0] frame_sp_o,
   output logic             frame_pad_o,
   output logic      [31:0] restored_sp_o
);

   logic [31:0] next_frame_sp;
   logic        next_frame_pad;
   logic [31:0] next_restored_sp;

   // A word-aligned but not double-word-aligned stack gets one padding word.
   // The pad flag travels in the stacked status word, so return needs no other state.
   always_comb begin
      next_frame_sp    = frame_sp_o;
      next_frame_pad   = frame_pad_o;
      next_restored_sp = restored_sp_o;
      if (exc_entry_i) begin
         next_frame_pad = entry_sp_i[2];
         next_frame_sp  = {entry_sp_i[31:3], 3'b000};
      end
      if (exc_return_i) begin
         next_restored_sp = stacked_psr_i[PSR_PAD_BIT] ?
                            frame_top_i + FRAME_PAD_BYTES : frame_top_i;
      end
   end

   // Results hold until the next entry or return.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         frame_sp_o    <= 32'h0000_0000;
         frame_pad_o   <= 1'b0;
         restored_sp_o <= 32'h0000_0000;
      end else begin
         frame_sp_o    <= next_frame_sp;
         frame_pad_o   <= next_frame_pad;
         restored_sp_o <= next_restored_sp;
      end
   end

   default clocking cb_sys @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   AST_ENTRY_PAD: assert property (
      exc_entry_i |=> (frame_pad_o == $past(entry_sp_i[2]))
                      && (frame_sp_o[2:0] == 3'b000)
                      && (frame_sp_o[31:3] == $past(entry_sp_i[31:3])))
      else $error("Frame pad flag or aligned pointer wrong after entry.");

   AST_RETURN_RESTORE: assert property (
      (exc_return_i && stacked_psr_i[PSR_PAD_BIT])
      |=> restored_sp_o == $past(frame_top_i) + FRAME_PAD_BYTES)
      else $error("Padding word not removed on exception return.");

endmodule

// >>> src/system_control_registers.sv
// System control register group with low-power wake logic and access checks.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ns
module system_control_registers
   import sysctl_pkg::*;
#(
   parameter int         IRQ_COUNT  = 32,
   parameter logic       BIG_ENDIAN = 1'b0
)(
   input  wire logic                  clk_sys_i,
   input  wire logic                  rstn_i,
   input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
   input  wire logic [31:0]           reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic      [31:0]           reg_rdata_o,
   input  wire logic [IRQ_COUNT-1:0]  irq_pending_i,
   input  wire logic [IRQ_COUNT-1:0]  irq_enable_i,
   input  wire logic                  ext_event_i,
   input  wire logic                  send_event_instruction_i,
   input  wire logic                  wait_for_event_instruction_i,
   input  wire logic                  wait_for_irq_i,
   input  wire logic                  handler_return_i,
   input  wire data_access_t          data_access_i,
   input  wire logic                  exc_entry_i,
   input  wire logic [31:0]           entry_sp_i,
   input  wire logic                  exc_return_i,
   input  wire logic [31:0]           frame_top_i,
   input  wire logic [31:0]           stacked_psr_i,
   output logic                       system_reset_request_o,
   output logic                       event_wait_o,
   output logic                       wake_o,
   output logic                       sleep_o,
   output logic                       deep_sleep_o,
   output logic                       hard_fault_exception_o,
   output logic      [31:0]           frame_sp_o,
   output logic                       frame_pad_o,
   output logic      [31:0]           restored_sp_o
);
   // ****************************************************************
   // Register access decode
   // ****************************************************************
   // True when the bus address selects the given register offset.
   function automatic logic hits(input logic [REG_ADDR_W-1:0] addr,
                                 input logic [REG_ADDR_W-1:0] ofs);
      hits = (addr == ofs);
   endfunction

   logic            keyed_app_write;
   logic            low_power_write;
   low_power_ctrl_t ctrl;
   low_power_ctrl_t next_ctrl;

   // A write without the key is dropped whole, so no field moves.
   assign keyed_app_write = reg_wr_i && hits(reg_addr_i, OFS_APP_CTRL)
                            && (reg_wdata_i[KEY_MSB:KEY_LSB] == WRITE_KEY);
   assign low_power_write = reg_wr_i && hits(reg_addr_i, OFS_LOW_POWER);

   // ****************************************************************
   // Low-power control register
   // ****************************************************************
   // Only the three defined bits are kept; all other written bits are dropped.
   always_comb begin
      next_ctrl = ctrl;
      if (low_power_write) begin
         next_ctrl.event_on_pending            = reg_wdata_i[EVENT_ON_PEND_BIT];
         next_ctrl.deep_low_power_select       = reg_wdata_i[DEEP_SELECT_BIT];
         next_ctrl.low_power_on_handler_return = reg_wdata_i[ON_RETURN_BIT];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl <= LOW_POWER_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // ****************************************************************
   // Reset request and read data
   // ****************************************************************
   logic        next_reset_req;
   logic [31:0] next_rdata;

   // The reset request is a one-cycle pulse; the bit itself is never stored.
   // Reads answer in the following cycle; unmapped offsets and idle cycles give zero.
   always_comb begin
      next_reset_req = keyed_app_write && reg_wdata_i[SYS_RESET_BIT];
      next_rdata     = 32'h0000_0000;
      if (reg_rd_i) begin
         if (hits(reg_addr_i, OFS_APP_CTRL)) begin
            // Key field, reset request and debug bit all read as zero.
            next_rdata[BYTE_ORDER_BIT] = BIG_ENDIAN;
         end else if (hits(reg_addr_i, OFS_LOW_POWER)) begin
            next_rdata[EVENT_ON_PEND_BIT] = ctrl.event_on_pending;
            next_rdata[DEEP_SELECT_BIT]   = ctrl.deep_low_power_select;
            next_rdata[ON_RETURN_BIT]     = ctrl.low_power_on_handler_return;
         end else if (hits(reg_addr_i, OFS_FIXED_CFG)) begin
            next_rdata = FIXED_CFG_VALUE;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         system_reset_request_o <= 1'b0;
         reg_rdata_o            <= 32'h0000_0000;
      end else begin
         system_reset_request_o <= next_reset_req;
         reg_rdata_o            <= next_rdata;
      end
   end

   // ****************************************************************
   // Event sources
   // ****************************************************************
   logic                 ev_meta;
   logic                 ev_sync;
   logic                 ev_prev;
   logic [IRQ_COUNT-1:0] pend_prev;
   logic [IRQ_COUNT-1:0] new_pend;
   logic [IRQ_COUNT-1:0] wake_pend;
   logic                 ev_rise;
   logic                 wake_event;

   // The event pin is asynchronous; only the second stage feeds the edge detector.
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ev_meta   <= 1'b0;
         ev_sync   <= 1'b0;
         ev_prev   <= 1'b0;
         pend_prev <= '0;
      end else begin
         ev_meta   <= ext_event_i;
         ev_sync   <= ev_meta;
         ev_prev   <= ev_sync;
         pend_prev <= irq_pending_i;
      end
   end

   // An interrupt counts as an event only on entry to pending, not while it stays there.
   assign new_pend  = irq_pending_i & ~pend_prev;
   assign wake_pend = ctrl.event_on_pending ? new_pend
                                            : (new_pend & irq_enable_i);
   assign ev_rise    = ev_sync && !ev_prev;
   assign wake_event = (|wake_pend) || ev_rise || send_event_instruction_i;

   // ****************************************************************
   // Power state and event latch
   // ****************************************************************
   power_state_t state;
   power_state_t next_state;
   logic         event_latch;
   logic         next_event_latch;
   logic         next_wake;
   logic         run_wfe;

   assign run_wfe = (state == PWR_RUN) && wait_for_event_instruction_i;

   // A waiting core is woken; otherwise the event is remembered for the next wait.
   // A new event in the cycle that a wait consumes the latch keeps it set.
   always_comb begin
      next_state       = state;
      next_wake        = 1'b0;
      next_event_latch = event_latch;
      if (run_wfe && !wake_event && event_latch) begin
         next_event_latch = 1'b0;
      end
      if (wake_event && (state != PWR_WAIT_EVENT)) begin
         next_event_latch = 1'b1;
      end
      case (state)
         PWR_RUN: begin
            if (wait_for_event_instruction_i) begin
               if (!event_latch && !wake_event) begin
                  next_state = PWR_WAIT_EVENT;
               end
            end else if (wait_for_irq_i) begin
               next_state = PWR_SLEEP;
            end else if (handler_return_i && ctrl.low_power_on_handler_return) begin
               next_state = PWR_SLEEP;
            end
         end
         PWR_WAIT_EVENT: begin
            if (wake_event) begin
               next_state = PWR_RUN;
               next_wake  = 1'b1;
            end
         end
         PWR_SLEEP: begin
            // Sleep ends on any enabled interrupt that is pending.
            if (|(irq_pending_i & irq_enable_i)) begin
               next_state = PWR_RUN;
               next_wake  = 1'b1;
            end
         end
         default: next_state = PWR_RUN;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state       <= PWR_RUN;
         event_latch <= 1'b0;
         wake_o      <= 1'b0;
      end else begin
         state       <= next_state;
         event_latch <= next_event_latch;
         wake_o      <= next_wake;
      end
   end

   // Both wait and sleep use the low-power mode that software selected.
   assign event_wait_o = (state == PWR_WAIT_EVENT);
   assign sleep_o      = (state != PWR_RUN) && !ctrl.deep_low_power_select;
   assign deep_sleep_o = (state != PWR_RUN) && ctrl.deep_low_power_select;

   // ****************************************************************
   // Misaligned access trap
   // ****************************************************************
   logic misaligned;
   logic next_fault;

   // Trapping is fixed on; there is no way to allow misaligned data accesses.
   always_comb begin
      misaligned = 1'b0;
      case (data_access_i.size)
         SIZE_HALF: misaligned = data_access_i.addr_lo[0];
         SIZE_WORD: misaligned = |data_access_i.addr_lo;
         default:   misaligned = 1'b0;
      endcase
      next_fault = data_access_i.valid && misaligned;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hard_fault_exception_o <= 1'b0;
      end else begin
         hard_fault_exception_o <= next_fault;
      end
   end

   // ****************************************************************
   // Exception frame alignment
   // ****************************************************************
   frame_align u_frame_align (
      .clk_sys_i     (clk_sys_i),
      .rstn_i        (rstn_i),
      .exc_entry_i   (exc_entry_i),
      .entry_sp_i    (entry_sp_i),
      .exc_return_i  (exc_return_i),
      .frame_top_i   (frame_top_i),
      .stacked_psr_i (stacked_psr_i),
      .frame_sp_o    (frame_sp_o),
      .frame_pad_o   (frame_pad_o),
      .restored_sp_o (restored_sp_o)
   );

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb_sys @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   // Steps of the wait-and-wake behaviour, shared by the wake checks below.
   sequence s_waiting;
      event_wait_o;
   endsequence
   sequence s_woken;
      !event_wait_o && wake_o && (state == PWR_RUN);
   endsequence

   AST_KEY_GUARD: assert property (
      (reg_wr_i && hits(reg_addr_i, OFS_APP_CTRL) && reg_wdata_i[KEY_MSB:KEY_LSB] != WRITE_KEY)
      |=> !system_reset_request_o)
      else $error("Unkeyed write raised a reset request.");
   AST_RESET_PULSE: assert property (
      (keyed_app_write && reg_wdata_i[SYS_RESET_BIT])
      |=> system_reset_request_o
          ##1 (!system_reset_request_o
               || ($past(keyed_app_write) && $past(reg_wdata_i[SYS_RESET_BIT]))))
      else $error("Reset request not a single pulse after keyed write.");
   AST_APP_READ: assert property (
      (reg_rd_i && hits(reg_addr_i, OFS_APP_CTRL))
      |=> reg_rdata_o == (32'h0000_0000 | (32'(BIG_ENDIAN) << BYTE_ORDER_BIT)))
      else $error("Reset control register read value wrong.");
   AST_FIXED_READ: assert property (
      (reg_rd_i && hits(reg_addr_i, OFS_FIXED_CFG))
      |=> reg_rdata_o[FRAME_ALIGN_BIT] && reg_rdata_o[MISALIGN_TRAP_BIT]
          && (reg_rdata_o == FIXED_CFG_VALUE))
      else $error("Fixed configuration register read value wrong.");
   AST_DISABLED_STAYS: assert property (
      ((!ctrl.event_on_pending && |new_pend && !(|(new_pend & irq_enable_i))
        && !ev_rise && !send_event_instruction_i) ##0 s_waiting)
      |=> s_waiting)
      else $error("Disabled interrupt woke the core.");
   AST_ANY_PEND_WAKES: assert property (
      ((ctrl.event_on_pending && |new_pend) ##0 s_waiting) |=> s_woken)
      else $error("Pending interrupt failed to wake the core.");
   AST_LATCH_SKIPS_WAIT: assert property (
      (state == PWR_RUN && wake_event && !wait_for_irq_i && !handler_return_i)
      ##1 (wait_for_event_instruction_i && !wait_for_irq_i) |=> (state == PWR_RUN))
      else $error("Latched event did not complete the next wait.");
   AST_SEV_WAKES: assert property (
      (send_event_instruction_i ##0 s_waiting) |=> s_woken)
      else $error("Send-event did not wake the core.");
   AST_MODE_SELECT: assert property (
      (state != PWR_RUN) |-> (deep_sleep_o == ctrl.deep_low_power_select)
                             && (sleep_o != deep_sleep_o))
      else $error("Low-power mode output disagrees with select bit.");
   AST_EXIT_SLEEP: assert property (
      (state == PWR_RUN && handler_return_i && !wait_for_event_instruction_i
       && !wait_for_irq_i)
      |=> ((state == PWR_SLEEP) == $past(ctrl.low_power_on_handler_return)))
      else $error("Sleep on handler return misbehaved.");
   AST_TRAP: assert property (
      data_access_i.valid
      |=> hard_fault_exception_o
          == ((($past(data_access_i.size) == SIZE_HALF) && $past(data_access_i.addr_lo[0]))
              || (($past(data_access_i.size) == SIZE_WORD)
                  && ($past(data_access_i.addr_lo) != 2'b00))))
      else $error("Misaligned access trap wrong.");
endmodule

// >>> test/tb_top.sv
// Self-checking testbench for the system control register group.
`timescale 1ns/1ns
module tb_top
   import sysctl_pkg::*;
;
   logic                  clk_sys_i;
   logic                  rstn_i;
   logic [REG_ADDR_W-1:0] reg_addr_i;
   logic [31:0]           reg_wdata_i, reg_rdata_o, entry_sp_i, frame_top_i, stacked_psr_i;
   logic [31:0]           frame_sp_o, restored_sp_o, irq_pending_i, irq_enable_i, rv;
   logic                  reg_wr_i, reg_rd_i, send_event_instruction_i;
   logic                  wait_for_event_instruction_i, handler_return_i, exc_entry_i;
   logic                  exc_return_i, system_reset_request_o, event_wait_o, wake_o;
   logic                  sleep_o, deep_sleep_o, hard_fault_exception_o, frame_pad_o;
   logic                  ext_event_i, wait_for_irq_i;
   data_access_t          data_access_i;
   int                    mismatches, tests_run;
   logic [7:0]            r_addr [5] = '{OFS_LOW_POWER, OFS_LOW_POWER, OFS_APP_CTRL,
                                         OFS_FIXED_CFG, 8'h20};
   logic [31:0]           r_wdata [5] = '{32'hffff_ffff, 32'h0000_0000, 32'h05fa_7ff8,
                                          32'h0000_0000, 32'h0000_00ff};
   logic [31:0]           r_exp [5] = '{32'h0000_0016, 32'h0, 32'h0, 32'h0000_0208, 32'h0};
   logic [31:0]           bad_key [3] = '{32'h05fb_0004, 32'h0000_0004, 32'h05fa_0000};

   // Every input is driven by the bench; the event pin goes through the synchroniser.
   system_control_registers system_control_registers_i (
      .clk_sys_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .irq_pending_i, .irq_enable_i, .ext_event_i, .send_event_instruction_i,
      .wait_for_event_instruction_i, .wait_for_irq_i, .handler_return_i,
      .data_access_i, .exc_entry_i, .entry_sp_i, .exc_return_i, .frame_top_i,
      .stacked_psr_i, .system_reset_request_o, .event_wait_o, .wake_o, .sleep_o,
      .deep_sleep_o, .hard_fault_exception_o, .frame_sp_o, .frame_pad_o, .restored_sp_o);

   // ****************************************************************
   // Clock, helpers and verdict
   // ****************************************************************
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   task tick;
      @(posedge clk_sys_i);
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task give_verdict;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Each of wr, rd, pulse and set_irq ends one step after its sampling edge so that registered answers are settled.
   task wr(input logic [7:0] a, input logic [31:0] d);
      tick;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      tick;
      reg_wr_i <= 1'b0;
      #1;
   endtask

   task rd(input logic [7:0] a);
      tick;
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      tick;
      reg_rd_i <= 1'b0;
      #1;
      rv = reg_rdata_o;
   endtask

   // Order of bits: send event, wait for event, handler return.
   task pulse(input logic [2:0] p);
      tick;
      {send_event_instruction_i, wait_for_event_instruction_i, handler_return_i} <= p;
      tick;
      {send_event_instruction_i, wait_for_event_instruction_i, handler_return_i} <= 3'b000;
      #1;
   endtask

   task set_irq(input logic [31:0] p, input logic [31:0] e);
      tick;
      irq_pending_i <= p;
      irq_enable_i <= e;
      tick;
      #1;
   endtask

   // A hang is cut short here rather than left to run forever.
   initial begin
      repeat (5000) tick;
      mismatches++;
      give_verdict;
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {rstn_i, reg_wr_i, reg_rd_i, exc_entry_i, exc_return_i, ext_event_i, wait_for_irq_i} = '0;
      {send_event_instruction_i, wait_for_event_instruction_i, handler_return_i} = '0;
      {reg_addr_i, reg_wdata_i, irq_pending_i, irq_enable_i} = '0;
      {entry_sp_i, frame_top_i, stacked_psr_i} = '0;
      data_access_i = '0;
      mismatches = 0;
      tests_run = 0;
      repeat (4) tick;
      check({deep_sleep_o, sleep_o, event_wait_o, wake_o, hard_fault_exception_o, frame_pad_o,
             system_reset_request_o}, 0);
      rstn_i <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         wr(r_addr[i], r_wdata[i]);
         check(system_reset_request_o, 0);
         rd(r_addr[i]);
         check(rv, r_exp[i]);
      end
      wr(OFS_APP_CTRL, 32'h05fa_0004);
      check(system_reset_request_o, 1);
      rd(OFS_APP_CTRL);
      check(system_reset_request_o, 0);
      check(rv, 0);
      foreach (bad_key[i]) begin
         wr(OFS_APP_CTRL, bad_key[i]);
         check(system_reset_request_o, 0);
      end
      wr(OFS_LOW_POWER, 32'h0000_0004);
      pulse(3'b010);
      check({event_wait_o, deep_sleep_o, sleep_o}, 3'b110);
      pulse(3'b100);
      check({event_wait_o, wake_o}, 2'b01);
      // Send-event then wait-for-event back to back: the latched event completes the wait.
      tick;
      send_event_instruction_i <= 1'b1;
      tick;
      {send_event_instruction_i, wait_for_event_instruction_i} <= 2'b01;
      tick;
      wait_for_event_instruction_i <= 1'b0;
      #1;
      check(event_wait_o, 0);
      wr(OFS_LOW_POWER, 32'h0);
      pulse(3'b010);
      check({event_wait_o, sleep_o}, 2'b11);
      set_irq(32'h1, 32'h0);
      check(event_wait_o, 1);
      set_irq(32'h3, 32'h2);
      check({event_wait_o, wake_o}, 2'b01);
      set_irq(32'h0, 32'h0);
      wr(OFS_LOW_POWER, 32'h0000_0010);
      pulse(3'b010);
      set_irq(32'h1, 32'h0);
      check({event_wait_o, wake_o}, 2'b01);
      set_irq(32'h0, 32'h0);
      wr(OFS_LOW_POWER, 32'h0000_0002);
      pulse(3'b001);
      check({sleep_o, event_wait_o}, 2'b10);
      set_irq(32'h4, 32'h4);
      check({sleep_o, wake_o}, 2'b01);
      set_irq(32'h0, 32'h0);
      wr(OFS_LOW_POWER, 32'h0);
      pulse(3'b001);
      check(sleep_o, 0);
      // The interrupt that ended sleep was latched, so the first wait completes at once.
      pulse(3'b010);
      check(event_wait_o, 0);
      pulse(3'b010);
      // The pin needs two synchroniser stages and an edge step before it wakes the core.
      tick;
      ext_event_i <= 1'b1;
      repeat (2) tick;
      #1;
      check(event_wait_o, 1);
      tick;
      #1;
      check({event_wait_o, wake_o}, 2'b01);
      tick;
      {ext_event_i, wait_for_irq_i} <= 2'b01;
      tick;
      wait_for_irq_i <= 1'b0;
      #1;
      check({sleep_o, event_wait_o}, 2'b10);
      set_irq(32'h8, 32'h8);
      check({sleep_o, wake_o}, 2'b01);
      for (int s = 0; s < 3; s++) begin
         for (int a = 0; a < 4; a++) begin
            tick;
            data_access_i <= '{1'b1, access_size_t'(s), a[1:0]};
            tick;
            data_access_i.valid <= 1'b0;
            #1;
            check(hard_fault_exception_o, (s == 1 && a[0]) || (s == 2 && a != 0));
         end
      end
      tick;
      exc_entry_i <= 1'b1;
      entry_sp_i <= 32'h0000_1004;
      exc_return_i <= 1'b1;
      frame_top_i <= 32'h0000_2000;
      stacked_psr_i <= 32'h0000_0200;
      tick;
      {exc_entry_i, exc_return_i} <= 2'b00;
      #1;
      check({frame_sp_o, frame_pad_o}, {32'h0000_1000, 1'b1});
      check(restored_sp_o, 32'h0000_2004);
      // Reset in mid-run must clear the writable control bits again.
      wr(OFS_LOW_POWER, 32'h0000_0016);
      rstn_i <= 1'b0;
      repeat (4) tick;
      rstn_i <= 1'b1;
      rd(OFS_LOW_POWER);
      check(rv, 0);
      give_verdict;
   end
endmodule
